// ==== hw/nand_host_pkg.sv ====
// Constants, register map and types for the cache read / program host controller
package nand_host_pkg;
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS     = 20;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_NS       = 100;
  localparam int TURN_CYC      = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC      = 2;

  // Flash command bytes
  localparam logic [7:0] CMD_READ        = 8'h00;
  localparam logic [7:0] CMD_READ_CONF   = 8'h30;
  localparam logic [7:0] CMD_CACHE_NEXT  = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST  = 8'h3f;
  localparam logic [7:0] CMD_COL_OUT     = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_END = 8'he0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_PROG        = 8'h80;
  localparam logic [7:0] CMD_COL_IN      = 8'h85;
  localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG  = 8'h15;

  // Device status byte bits
  localparam int SR_PASS_FAIL  = 0;
  localparam int SR_PREV_PF    = 1;
  localparam int SR_ARRAY_IDLE = 5;
  localparam int SR_CACHE_RDY  = 6;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CFG    = 8'h14;

  // Field layout
  localparam int COL_W       = 12;
  localparam int ROW_LSB     = 16;
  localparam int ROW_W       = 16;
  localparam int PAGE_W      = 6;
  localparam int OP_W        = 4;
  localparam int ST_BUSY     = 0;
  localparam int ST_READY    = 1;
  localparam int ST_REFUSED  = 2;
  localparam int ST_CACHE_RD = 3;
  localparam int ST_LOADING  = 4;
  localparam int ST_PROGFAIL = 5;
  localparam int ST_PARTIAL  = 8;
  localparam int CFG_WP_OFF  = 0;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  localparam logic [2:0] ADDR_FULL   = 3'h4;
  localparam logic [2:0] ADDR_COL    = 3'h2;

  typedef enum logic [3:0] {
    OP_NONE, OP_READ_START, OP_READ_NEXT, OP_READ_LAST, OP_READ_PAGE, OP_COL_OUT,
    OP_STATUS, OP_PROG_LOAD, OP_COL_IN, OP_CONFIRM, OP_CACHE_CONF, OP_RD_BYTE, OP_WR_BYTE
  } op_t;

  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_DIN, CYC_DOUT} cyc_t;
  typedef enum logic [1:0] {DATA_NONE, DATA_RD, DATA_WR} data_t;
endpackage : nand_host_pkg

// ==== hw/nand_bus_cycle.sv ====
// One strobed cycle on the flash pins: command, address, data in or data out
`timescale 1ns/1ps
`default_nettype none
module nand_bus_cycle
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Request from sequencer
  input  wire logic       start,
  input  wire cyc_t       kind,
  input  wire logic [7:0] byteIn,
  output logic            done,
  output logic [7:0]      byteOut,
  // Flash pins
  output logic            cle,
  output logic            ale,
  output logic            weN,
  output logic            read_strobe_n,
  output logic [7:0]      ioOut,
  output logic            ioOe,
  input  wire logic [7:0] ioInSync
);
  typedef enum logic [1:0] {B_IDLE, B_LOW, B_HIGH} bstate_t;
  bstate_t     state_q, state_d;
  logic [7:0]  cnt_q, cnt_d, byteOut_d;
  logic        cle_d, ale_d, weN_d, reN_d, ioOe_d;
  logic [7:0]  ioOut_d;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    byteOut_d = byteOut;
    cle_d     = cle;
    ale_d     = ale;
    weN_d     = weN;
    reN_d     = read_strobe_n;
    ioOe_d    = ioOe;
    ioOut_d   = ioOut;
    done      = 1'b0;
    unique case (state_q)
      B_IDLE: if (start) begin
        state_d = B_LOW;
        cle_d   = (kind == CYC_CMD);
        ale_d   = (kind == CYC_ADDR);
        ioOe_d  = (kind != CYC_DOUT);
        ioOut_d = byteIn;
        weN_d   = (kind == CYC_DOUT);
        reN_d   = (kind != CYC_DOUT);
        // Read data passes the pin synchroniser, so the low phase is stretched
        cnt_d   = (kind == CYC_DOUT) ? 8'(STROBE_CYC + SYNC_CYC - 1) : 8'(STROBE_CYC - 1);
      end
      B_LOW: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          if (!read_strobe_n) begin
            byteOut_d = ioInSync;
          end
          weN_d   = 1'b1;
          reN_d   = 1'b1;
          cnt_d   = 8'(STROBE_CYC - 1);
          state_d = B_HIGH;
        end
      end
      B_HIGH: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          done    = 1'b1;
          cle_d   = 1'b0;
          ale_d   = 1'b0;
          ioOe_d  = 1'b0;
          state_d = B_IDLE;
        end
      end
      default: state_d = B_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= B_IDLE;
      cnt_q         <= 8'h00;
      byteOut       <= 8'h00;
      cle           <= 1'b0;
      ale           <= 1'b0;
      weN           <= 1'b1;
      read_strobe_n <= 1'b1;
      ioOe          <= 1'b0;
      ioOut         <= 8'h00;
    end else begin
      state_q       <= state_d;
      cnt_q         <= cnt_d;
      byteOut       <= byteOut_d;
      cle           <= cle_d;
      ale           <= ale_d;
      weN           <= weN_d;
      read_strobe_n <= reN_d;
      ioOe          <= ioOe_d;
      ioOut         <= ioOut_d;
    end
  end
endmodule : nand_bus_cycle
`default_nettype wire

// ==== hw/nand_cache_host.sv ====
// Host controller sequencing cache read and page/cache program on a NAND flash
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Cache read start: 00h, address, 30h, wait
// - 05h, column cycles, E0h change output column
// - After status in cache read, send 00h
// - 3Fh instead of 31h ends cache read
// - Random page reselect repeats 00h, address, 31h
// - Program: 80h, address, data, then 10h
// - 85h with column redirects data load
// - Program pages of block in ascending order
// - At most four partial programs per page
// - Cache program confirms with 15h
// - Next cache program only when cache ready
// - Last page confirmed with 10h, watching pin
// - Command/address latched by rising write strobe
// - Address: two column then two row cycles
module nand_cache_host
  import nand_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Flash pins
  output logic             ceN,
  output logic             cle,
  output logic             ale,
  output logic             weN,
  output logic             read_strobe_n,
  output logic             wpN,
  output logic [7:0]       ioOut,
  output logic             ioOe,
  input  wire logic [7:0]  ioIn,
  input  wire logic        readyBusyN
);
  typedef enum logic [2:0] {S_IDLE, S_PRE, S_ADDR, S_POST, S_WAIT, S_RB, S_DATA, S_TAIL} sstate_t;

  // Register group
  logic             wrPend_q, wrPend_d;
  logic [7:0]       wrAddr_q, wrAddr_d;
  logic [31:0]      addr_q, addr_d, hrdata_d;
  logic [7:0]       wdata_q, wdata_d;
  logic             cfgWpOff_q, cfgWpOff_d;
  // Sequencer group
  sstate_t          state_q, state_d;
  op_t              op_q, op_d, reqOp;
  logic [2:0]       idx_q, idx_d;
  logic [7:0]       cnt_q, cnt_d, rdata_q, rdata_d;
  logic             pend_q, pend_d;
  logic             cacheRd_q, cacheRd_d, loading_q, loading_d;
  logic             refused_q, refused_d, progFail_q, progFail_d;
  logic [ROW_W-1:0] lastRow_q, lastRow_d;
  logic [2:0]       partial_q, partial_d;
  // Pin synchronisers; first stages feed only the second stages
  logic [7:0]       ioMeta_q, ioSync_q;
  logic             rbMeta_q, rbSync_q;
  // Bus cycle engine
  logic             cycStart, cycDone;
  cyc_t             cycKind;
  logic [7:0]       cycByte, cycOut;
  // Operation decode
  logic             hasPre, hasPost, waitRb, ok, ctrlWr, statWr;
  logic [7:0]       preCmd, postCmd, addrByte;
  logic [2:0]       nAddr;
  data_t            dataKind;
  logic [ROW_W-1:0] reqRow;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wpN       = cfgWpOff_q;
  assign ceN       = !(cacheRd_q || loading_q || state_q != S_IDLE);
  assign ctrlWr    = wrPend_q && wrAddr_q == REG_CTRL;
  assign statWr    = wrPend_q && wrAddr_q == REG_STATUS;
  assign reqOp     = op_t'(hwdata[OP_W-1:0]);
  assign reqRow    = addr_q[ROW_LSB +: ROW_W];

  // AHB-Lite registers; zero wait states, unmapped reads give zero
  always_comb begin
    wrPend_d   = hsel && htrans[1] && hready && hwrite;
    wrAddr_d   = haddr[7:0];
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    cfgWpOff_d = cfgWpOff_q;
    hrdata_d   = 32'h0000_0000;
    if (wrPend_q) begin
      unique case (wrAddr_q)
        REG_ADDR:  addr_d = {hwdata[31:ROW_LSB], 4'h0, hwdata[COL_W-1:0]};
        REG_WDATA: wdata_d = hwdata[7:0];
        REG_CFG:   cfgWpOff_d = hwdata[CFG_WP_OFF];
        default:   addr_d = addr_q;
      endcase
    end
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        REG_ADDR:   hrdata_d = addr_q;
        REG_WDATA:  hrdata_d = {24'h000000, wdata_q};
        REG_RDATA:  hrdata_d = {24'h000000, rdata_q};
        REG_CFG:    hrdata_d = {31'h0000_0000, cfgWpOff_q};
        REG_STATUS: begin
          hrdata_d[ST_BUSY]              = state_q != S_IDLE;
          hrdata_d[ST_READY]             = rbSync_q;
          hrdata_d[ST_REFUSED]           = refused_q;
          hrdata_d[ST_CACHE_RD]          = cacheRd_q;
          hrdata_d[ST_LOADING]           = loading_q;
          hrdata_d[ST_PROGFAIL]          = progFail_q;
          hrdata_d[ST_PARTIAL +: 3]      = partial_q;
        end
        default:    hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_q   <= 1'b0;
      wrAddr_q   <= 8'h00;
      addr_q     <= 32'h0000_0000;
      wdata_q    <= 8'h00;
      cfgWpOff_q <= 1'b0;
      hrdata     <= 32'h0000_0000;
    end else begin
      wrPend_q   <= wrPend_d;
      wrAddr_q   <= wrAddr_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      cfgWpOff_q <= cfgWpOff_d;
      hrdata     <= hrdata_d;
    end
  end

  // Shape of each operation on the pins
  always_comb begin
    hasPre   = 1'b1;
    preCmd   = CMD_READ;
    nAddr    = 3'h0;
    hasPost  = 1'b0;
    postCmd  = CMD_READ;
    waitRb   = 1'b0;
    dataKind = DATA_NONE;
    unique case (op_q)
      OP_READ_START: begin
        nAddr   = ADDR_FULL;
        hasPost = 1'b1;
        postCmd = CMD_READ_CONF;
        waitRb  = 1'b1;
      end
      OP_READ_NEXT: begin
        preCmd = CMD_CACHE_NEXT;
        waitRb = 1'b1;
      end
      OP_READ_LAST: begin
        preCmd = CMD_CACHE_LAST;
        waitRb = 1'b1;
      end
      OP_READ_PAGE: begin
        nAddr   = ADDR_FULL;
        hasPost = 1'b1;
        postCmd = CMD_CACHE_NEXT;
        waitRb  = 1'b1;
      end
      OP_COL_OUT: begin
        preCmd  = CMD_COL_OUT;
        nAddr   = ADDR_COL;
        hasPost = 1'b1;
        postCmd = CMD_COL_OUT_END;
      end
      OP_STATUS: begin
        preCmd   = CMD_STATUS;
        dataKind = DATA_RD;
      end
      OP_PROG_LOAD: begin
        preCmd = CMD_PROG;
        nAddr  = ADDR_FULL;
      end
      OP_COL_IN: begin
        preCmd = CMD_COL_IN;
        nAddr  = ADDR_COL;
      end
      OP_CONFIRM: begin
        preCmd = CMD_PROG_CONF;
        waitRb = 1'b1;
      end
      OP_CACHE_CONF: begin
        preCmd = CMD_CACHE_PROG;
        waitRb = 1'b1;
      end
      OP_RD_BYTE: begin
        hasPre   = 1'b0;
        dataKind = DATA_RD;
      end
      OP_WR_BYTE: begin
        hasPre   = 1'b0;
        dataKind = DATA_WR;
      end
      default: hasPre = 1'b0;
    endcase
    unique case (idx_q)
      3'h0:    addrByte = addr_q[7:0];
      3'h1:    addrByte = {4'h0, addr_q[COL_W-1:8]};
      3'h2:    addrByte = reqRow[7:0];
      default: addrByte = reqRow[15:8];
    endcase
  end

  // Whether a requested operation may go out now
  always_comb begin
    ok = rbSync_q || reqOp == OP_STATUS || reqOp == OP_RD_BYTE;
    unique case (reqOp)
      OP_READ_START: ok = ok && !loading_q;
      OP_READ_NEXT, OP_READ_LAST, OP_READ_PAGE, OP_COL_OUT: ok = ok && cacheRd_q;
      OP_PROG_LOAD: begin
        ok = ok && !cacheRd_q && !loading_q;
        if (reqRow == lastRow_q) begin
          ok = ok && partial_q < MAX_PARTIAL;
        end else if (reqRow[ROW_W-1:PAGE_W] == lastRow_q[ROW_W-1:PAGE_W]) begin
          ok = ok && reqRow[PAGE_W-1:0] > lastRow_q[PAGE_W-1:0];
        end
      end
      OP_COL_IN, OP_WR_BYTE, OP_CONFIRM, OP_CACHE_CONF: ok = ok && loading_q;
      OP_STATUS, OP_RD_BYTE: ok = 1'b1;
      default: ok = 1'b0;
    endcase
  end

  // Sequencer
  always_comb begin
    state_d    = state_q;
    op_d       = op_q;
    idx_d      = idx_q;
    cnt_d      = cnt_q;
    rdata_d    = rdata_q;
    cacheRd_d  = cacheRd_q;
    loading_d  = loading_q;
    lastRow_d  = lastRow_q;
    partial_d  = partial_q;
    refused_d  = refused_q && !(statWr && hwdata[ST_REFUSED]);
    progFail_d = progFail_q && !(statWr && hwdata[ST_PROGFAIL]);
    cycStart   = 1'b0;
    cycKind    = CYC_CMD;
    cycByte    = preCmd;
    // A request arriving while busy is refused, never queued
    if (ctrlWr && (state_q != S_IDLE || !ok)) begin
      refused_d = 1'b1;
    end
    unique case (state_q)
      S_IDLE: if (ctrlWr && ok) begin
        op_d    = reqOp;
        idx_d   = 3'h0;
        state_d = S_PRE;
        unique case (reqOp)
          OP_READ_START: cacheRd_d = 1'b1;
          OP_READ_LAST:  cacheRd_d = 1'b0;
          OP_PROG_LOAD: begin
            loading_d = 1'b1;
            lastRow_d = reqRow;
            partial_d = (reqRow == lastRow_q) ? partial_q + 3'h1 : 3'h1;
          end
          OP_CONFIRM, OP_CACHE_CONF: loading_d = 1'b0;
          default: loading_d = loading_q;
        endcase
      end
      S_PRE: begin
        if (!hasPre) begin
          state_d = S_ADDR;
        end else begin
          cycStart = !pend_q;
          if (cycDone) begin
            state_d = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        if (idx_q >= nAddr) begin
          state_d = S_POST;
        end else begin
          cycStart = !pend_q;
          cycKind  = CYC_ADDR;
          cycByte  = addrByte;
          if (cycDone) begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      S_POST: begin
        cnt_d = 8'(TURN_CYC - 1);
        if (!hasPost) begin
          state_d = S_WAIT;
        end else begin
          cycStart = !pend_q;
          cycByte  = postCmd;
          if (cycDone) begin
            state_d = S_WAIT;
          end
        end
      end
      // Busy indication lags the confirm, so the pin is not trusted at once
      S_WAIT: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          state_d = waitRb ? S_RB : S_DATA;
        end
      end
      S_RB: if (rbSync_q) begin
        state_d = S_DATA;
      end
      S_DATA: begin
        if (dataKind == DATA_NONE) begin
          state_d = S_TAIL;
        end else begin
          cycStart = !pend_q;
          cycKind  = (dataKind == DATA_RD) ? CYC_DOUT : CYC_DIN;
          cycByte  = wdata_q;
          if (cycDone) begin
            state_d = S_TAIL;
            if (dataKind == DATA_RD) begin
              rdata_d = cycOut;
            end
            if (op_q == OP_STATUS && (cycOut[SR_PASS_FAIL] || cycOut[SR_PREV_PF])) begin
              progFail_d = 1'b1;
            end
          end
        end
      end
      S_TAIL: begin
        if (op_q == OP_STATUS && cacheRd_q) begin
          cycStart = !pend_q;
          cycByte  = CMD_READ;
          if (cycDone) begin
            state_d = S_IDLE;
          end
        end else begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
    pend_d = (pend_q || cycStart) && !cycDone;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= S_IDLE;
      op_q       <= OP_NONE;
      idx_q      <= 3'h0;
      cnt_q      <= 8'h00;
      rdata_q    <= 8'h00;
      pend_q     <= 1'b0;
      cacheRd_q  <= 1'b0;
      loading_q  <= 1'b0;
      refused_q  <= 1'b0;
      progFail_q <= 1'b0;
      lastRow_q  <= '1;
      partial_q  <= 3'h0;
      ioMeta_q   <= 8'h00;
      ioSync_q   <= 8'h00;
      rbMeta_q   <= 1'b0;
      rbSync_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      op_q       <= op_d;
      idx_q      <= idx_d;
      cnt_q      <= cnt_d;
      rdata_q    <= rdata_d;
      pend_q     <= pend_d;
      cacheRd_q  <= cacheRd_d;
      loading_q  <= loading_d;
      refused_q  <= refused_d;
      progFail_q <= progFail_d;
      lastRow_q  <= lastRow_d;
      partial_q  <= partial_d;
      ioMeta_q   <= ioIn;
      ioSync_q   <= ioMeta_q;
      rbMeta_q   <= readyBusyN;
      rbSync_q   <= rbMeta_q;
    end
  end

  nand_bus_cycle u_cycle (
    .clk           (clk),
    .nrst          (nrst),
    .start         (cycStart),
    .kind          (cycKind),
    .byteIn        (cycByte),
    .done          (cycDone),
    .byteOut       (cycOut),
    .cle           (cle),
    .ale           (ale),
    .weN           (weN),
    .read_strobe_n (read_strobe_n),
    .ioOut         (ioOut),
    .ioOe          (ioOe),
    .ioInSync      (ioSync_q)
  );
endmodule : nand_cache_host
`default_nettype wire

// ==== verification/nand_flash_model.sv ====
// Behavioural flash device answering the host's pins
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model #(
  parameter int BUSY = 20
) (
  // Clock, host pins and bench fail injection
  input  wire logic       clk,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       weN,
  input  wire logic       read_strobe_n,
  input  wire logic [7:0] io,
  input  wire logic       failNext,
  // Device answers
  output logic [7:0]      ioDrv,
  output logic            readyBusyN
);
  logic [15:0] row, nxt, outRow;
  logic [11:0] acol, col;
  logic [7:0]  dout = 8'h00;
  logic [1:0]  n;
  logic        weP = 1'b1;
  logic        reP = 1'b1;
  logic        stat, newAddr;
  logic        pf = 1'b0;
  logic        pf1 = 1'b0;
  int          bsy = 0;
  assign readyBusyN = (bsy == 0);
  // Released bus shows the inverse, so a stale byte never passes
  assign ioDrv = read_strobe_n ? ~dout : dout;
  always @(posedge clk) begin
    weP <= weN;
    reP <= read_strobe_n;
    // Chip enable is not watched, so a deselect never cuts a busy phase
    if (bsy > 0) bsy <= bsy - 1;
    if (reP && !read_strobe_n) begin
      dout <= stat ? {1'b1, readyBusyN, bsy == 0, 3'h0, pf1, pf} : outRow[7:0] ^ col[7:0];
      // Status reads leave the page column where it was
      if (!stat) col <= col + 12'h1;
    end
    if (!weP && weN && ale) begin
      n <= n + 2'h1;
      newAddr <= 1'b1;
      case (n)
        2'h0: acol[7:0] <= io;
        2'h1: acol[11:8] <= io[3:0];
        2'h2: row[7:0] <= io;
        default: row[15:8] <= io;
      endcase
    end
    if (!weP && weN && cle && (bsy == 0 || io == 8'h70 || io == 8'h00)) begin
      stat <= (io == 8'h70);
      n <= 2'h0;
      case (io)
        8'h00: newAddr <= 1'b0;
        8'h30: begin
          nxt <= row;
          bsy <= BUSY;
        end
        8'h31, 8'h3f: begin
          outRow <= newAddr ? row : nxt;
          newAddr <= 1'b0;
          nxt <= (newAddr ? row : nxt) + 16'h1;
          col <= 12'h0;
          bsy <= BUSY / 2;
        end
        8'he0: col <= acol;
        8'h10, 8'h15: begin
          pf1 <= pf;
          pf <= failNext;
          bsy <= (io == 8'h10) ? BUSY : BUSY / 2;
        end
        default: ;
      endcase
    end
  end
endmodule : nand_flash_model
`default_nettype wire

// ==== verification/nand_cache_host_chk.sv ====
// Pin-level checks on the host controller
`timescale 1ns/1ps
`default_nettype none
module nand_cache_host_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Flash pins
  input wire logic       ceN,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       weN,
  input wire logic       read_strobe_n,
  input wire logic       ioOe,
  input wire logic [7:0] ioOut,
  input wire logic       readyBusyN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  latch_excl_a:
    assert property (!(cle && ale)) else $error("both latch enables high");
  cmd_drive_a:
    assert property ($rose(weN) && (cle || ale) |-> ioOe && $stable(ioOut))
    else $error("latched byte not held");
  write_pulse_a:
    assert property ($fell(weN) |-> ##1 !weN ##1 weN[*2]) else $error("write strobe width");
  read_pulse_a:
    assert property ($fell(read_strobe_n) |-> !read_strobe_n[*4] ##1 read_strobe_n)
    else $error("read strobe width");
  strobe_excl_a:
    assert property (weN || read_strobe_n) else $error("both strobes low");
  strobe_select_a:
    assert property (!weN || !read_strobe_n |-> !ceN) else $error("strobe while deselected");
  busy_cmd_a:
    assert property ($rose(weN) && cle && !readyBusyN |-> ioOut inside {8'h70, 8'h00})
    else $error("command while busy");
  read_release_a:
    assert property (!read_strobe_n |-> !ioOe) else $error("bus driven during read");
  cover property ($rose(weN) && cle && ioOut == 8'h31);
  cover property ($rose(weN) && cle && ioOut == 8'h3f);
  cover property ($rose(weN) && cle && ioOut == 8'h15);
endmodule : nand_cache_host_chk
bind nand_cache_host nand_cache_host_chk i_chk (.clk(clk), .nrst(nrst), .ceN(ceN), .cle(cle),
  .ale(ale), .weN(weN), .read_strobe_n(read_strobe_n), .ioOe(ioOe), .ioOut(ioOut),
  .readyBusyN(readyBusyN));
`default_nettype wire

// ==== verification/nand_cache_host_bench.sv ====
// Self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module nand_cache_host_bench
  import nand_host_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hwrite = 1'b0;
  logic        failNext = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, ceN, cle, ale, weN, rsN, wpN, ioOe, readyBusyN;
  logic [7:0]  ioOut, ioDrv, ioBus;
  logic [15:0] row, row2;
  logic [11:0] col;
  int          fail_count = 0;
  int          checks = 0;
  assign ioBus = ioOe ? ioOut : ioDrv;
  always #5 clk = ~clk;
  nand_cache_host i_dut (.clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
    .read_strobe_n(rsN), .wpN(wpN), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioBus),
    .readyBusyN(readyBusyN));
  nand_flash_model i_dev (.clk(clk), .cle(cle), .ale(ale), .weN(weN), .read_strobe_n(rsN),
    .io(ioBus), .failNext(failNext), .ioDrv(ioDrv), .readyBusyN(readyBusyN));
  function automatic logic [31:0] pat(input logic [15:0] r, input logic [11:0] c);
    return {24'h0, r[7:0] ^ c[7:0]};
  endfunction : pat
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  // Waits on the busy flag; a hang is cut by the watchdog
  task automatic op(input op_t o);
    bus(1'b1, REG_CTRL, {28'h0, o});
    bus(1'b0, REG_STATUS, 32'h0);
    while (q[ST_BUSY] !== 1'b0) bus(1'b0, REG_STATUS, 32'h0);
  endtask : op
  task automatic rdb(input logic [31:0] e);
    op(OP_RD_BYTE);
    bus(1'b0, REG_RDATA, 32'h0);
    chk(q, e);
  endtask : rdb
  task automatic refused(input op_t o);
    op(o);
    chk({31'h0, q[ST_REFUSED]}, 32'h1);
    bus(1'b1, REG_STATUS, 32'h4);
  endtask : refused
  task automatic load(input logic [15:0] r);
    bus(1'b1, REG_ADDR, {r, 16'h0});
    op(OP_PROG_LOAD);
    bus(1'b1, REG_WDATA, $urandom & 32'hff);
    op(OP_WR_BYTE);
  endtask : load
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    q = $urandom(1);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, 8'h40, 32'h5);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, REG_CFG, 32'h1);
    bus(1'b0, REG_CFG, 32'h0);
    chk(q, 32'h1);
    chk({30'h0, wpN, hresp}, 32'h2);
    $display("test registers done");
    // Start on the last page of a block so the second page crosses it
    row = {16'($urandom) & 16'hffc0} | 16'h003f;
    col = 12'($urandom);
    bus(1'b1, REG_ADDR, {row, 4'h0, col});
    op(OP_READ_START);
    op(OP_READ_NEXT);
    rdb(pat(row, 12'h0));
    rdb(pat(row, 12'h1));
    op(OP_READ_NEXT);
    rdb(pat(row + 16'h1, 12'h0));
    bus(1'b1, REG_ADDR, {row, 4'h0, col});
    op(OP_COL_OUT);
    rdb(pat(row + 16'h1, col));
    op(OP_STATUS);
    bus(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'he0);
    rdb(pat(row + 16'h1, col + 12'h1));
    row2 = 16'($urandom);
    bus(1'b1, REG_ADDR, {row2, 4'h0, 12'($urandom)});
    op(OP_READ_PAGE);
    rdb(pat(row2, 12'h0));
    op(OP_READ_LAST);
    rdb(pat(row2 + 16'h1, 12'h0));
    refused(OP_READ_NEXT);
    $display("test cache read done");
    row = {16'($urandom) & 16'hffc0} | 16'h0005;
    load(row);
    bus(1'b1, REG_ADDR, {row, 4'h0, 12'($urandom)});
    op(OP_COL_IN);
    op(OP_WR_BYTE);
    op(OP_CONFIRM);
    op(OP_STATUS);
    bus(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'he0);
    failNext <= 1'b1;
    load(row + 16'h1);
    op(OP_CONFIRM);
    op(OP_STATUS);
    bus(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'he1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, q[ST_PROGFAIL]}, 32'h1);
    bus(1'b1, REG_STATUS, 32'h20);
    failNext <= 1'b0;
    load(row + 16'h2);
    op(OP_CACHE_CONF);
    op(OP_STATUS);
    bus(1'b0, REG_RDATA, 32'h0);
    chk(q, 32'he2);
    load(row + 16'h3);
    bus(1'b1, REG_CTRL, {28'h0, OP_CONFIRM});
    refused(OP_PROG_LOAD);
    bus(1'b1, REG_ADDR, {row, 16'h0});
    refused(OP_PROG_LOAD);
    // Same page again: three more partial programs pass, the fifth is refused
    repeat (3) begin
      load(row + 16'h3);
      op(OP_CONFIRM);
    end
    bus(1'b0, REG_STATUS, 32'h0);
    chk({29'h0, q[ST_PARTIAL +: 3]}, 32'h4);
    bus(1'b1, REG_ADDR, {row + 16'h3, 16'h0});
    refused(OP_PROG_LOAD);
    $display("test program done");
    complete_run();
  end
endmodule : nand_cache_host_bench
`default_nettype wire
